// *** src/ocfl_top.sv ***
// operating counters, monitor readouts and ten-deep fault history behind APB
`timescale 1ns/1ns
`include "ocfl_map.svh"
module ocfl_top #(
  parameter int SEC_CYC        = `OCFL_CLOCK_HZ,
  parameter int FAN_GATE_CYC   = `OCFL_CLOCK_HZ,
  parameter int FAN_PULSES_REV = 2,
  parameter int ENC_LINES      = 1024,
  parameter int ENC_WIN_CYC    = 60 * `OCFL_CLOCK_HZ / ENC_LINES,
  parameter int OVL_TICK_CYC   = `OCFL_CLOCK_HZ / 100,
  parameter int HIST_DEPTH     = 10
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fan_tach_pulse,
  input  wire logic        fan_running,
  input  wire logic        enc_step,
  input  wire logic        enc_dir_cw,
  input  wire logic        ovl_over_current,
  input  wire logic        drive_enabled,
  input  wire logic        energy_wh_pulse,
  input  wire logic [9:0]  alarm_number,
  input  wire logic        fault_event,
  input  wire logic [9:0]  fault_number,
  input  wire logic        fault_clear,
  input  wire logic [4:0]  rtc_day,
  input  wire logic [3:0]  rtc_month,
  input  wire logic [6:0]  rtc_year,
  input  wire logic [4:0]  rtc_hour,
  input  wire logic [5:0]  rtc_minute,
  input  wire logic        rtc_valid,
  input  wire logic        nv_load,
  input  wire logic [1:0]  nv_sel,
  input  wire logic [15:0] nv_data,
  output logic             motor_overload_fault,
  output logic [15:0]      ao1_data,
  output logic [15:0]      ao2_data
);

  // ==================================================
  // reset release
  logic rst_meta_r;
  logic rst_s_b;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_s_b    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_s_b    <= rst_meta_r;
    end
  end

  // ==================================================
  // apb access
  logic        wr_en;
  logic [15:0] wword;
  logic [15:0] cnt_cmd;
  assign wr_en   = psel & penable & pready & pwrite;
  assign wword   = pwdata[15:0];
  assign cnt_cmd = (wr_en && paddr == `OCFL_CNT_RST_CMD_OFS) ? wword : 16'h0000;

  // ==================================================
  // second and overload ticks
  logic [31:0] sec_cnt_r;
  logic        sec_tick;
  logic [31:0] ovl_cnt_r;
  logic        ovl_tick;
  assign sec_tick = (sec_cnt_r == 32'(SEC_CYC - 1));
  assign ovl_tick = (ovl_cnt_r == 32'(OVL_TICK_CYC - 1));
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      sec_cnt_r <= 32'h0000_0000;
      ovl_cnt_r <= 32'h0000_0000;
    end else begin
      sec_cnt_r <= sec_tick ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
      ovl_cnt_r <= ovl_tick ? 32'h0000_0000 : ovl_cnt_r + 32'h0000_0001;
    end
  end

  // ==================================================
  // motor overload
  logic [15:0] ovl_level_r;
  logic        ovl_fault_rise;
  assign ovl_fault_rise = (ovl_level_r == `OCFL_OVL_FULL) & ~motor_overload_fault;
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      ovl_level_r          <= 16'h0000;
      motor_overload_fault <= 1'b0;
    end else begin
      if (ovl_tick) begin
        if (ovl_over_current && ovl_level_r < `OCFL_OVL_FULL)
          ovl_level_r <= ovl_level_r + 16'h0001;
        else if (!ovl_over_current && ovl_level_r != 16'h0000)
          ovl_level_r <= ovl_level_r - 16'h0001;
      end
      // held until the fault is acknowledged while the level is below full
      if (ovl_level_r == `OCFL_OVL_FULL)
        motor_overload_fault <= 1'b1;
      else if (fault_clear)
        motor_overload_fault <= 1'b0;
    end
  end

  // ==================================================
  // encoder count and speed
  logic [15:0] enc_count_r;
  logic [31:0] enc_win_r;
  logic [15:0] enc_steps_r;
  logic [18:0] spd_acc_r;
  logic [15:0] enc_speed_r;
  logic        enc_win_end;
  assign enc_win_end = (enc_win_r == 32'(ENC_WIN_CYC - 1));
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      enc_count_r <= 16'h0000;
    end else if (enc_step) begin
      if (enc_dir_cw)
        enc_count_r <= (enc_count_r >= `OCFL_ENC_MAX) ? 16'h0000 : enc_count_r + 16'h0001;
      else
        enc_count_r <= (enc_count_r == 16'h0000) ? `OCFL_ENC_MAX : enc_count_r - 16'h0001;
    end
  end

  // window of one line period per rpm, so steps per window equal rpm
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      enc_win_r   <= 32'h0000_0000;
      enc_steps_r <= 16'h0000;
      spd_acc_r   <= 19'h00000;
      enc_speed_r <= 16'h0000;
    end else begin
      enc_win_r <= enc_win_end ? 32'h0000_0000 : enc_win_r + 32'h0000_0001;
      if (enc_win_end) begin
        enc_steps_r <= {15'h0000, enc_step};
        // first-order smoothing, shift chosen for about half a second
        spd_acc_r   <= spd_acc_r - (spd_acc_r >> `OCFL_SPD_SHIFT)
                       + {3'h0, enc_steps_r};
        enc_speed_r <= spd_acc_r[18:3];
      end else if (enc_step && enc_steps_r != 16'hffff) begin
        enc_steps_r <= enc_steps_r + 16'h0001;
      end
    end
  end

  // ==================================================
  // fan speed
  logic [31:0] fan_gate_r;
  logic [15:0] fan_pulses_r;
  logic [15:0] fan_rpm_r;
  logic [31:0] fan_calc;
  assign fan_calc = 32'(fan_pulses_r) * 32'(60 / FAN_PULSES_REV);
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      fan_gate_r   <= 32'h0000_0000;
      fan_pulses_r <= 16'h0000;
      fan_rpm_r    <= 16'h0000;
    end else if (fan_gate_r == 32'(FAN_GATE_CYC - 1)) begin
      fan_gate_r   <= 32'h0000_0000;
      fan_pulses_r <= {15'h0000, fan_tach_pulse};
      fan_rpm_r    <= (fan_calc > 32'(`OCFL_FAN_MAX)) ? `OCFL_FAN_MAX : fan_calc[15:0];
    end else begin
      fan_gate_r <= fan_gate_r + 32'h0000_0001;
      if (fan_tach_pulse && fan_pulses_r != 16'hffff)
        fan_pulses_r <= fan_pulses_r + 16'h0001;
    end
  end

  // ==================================================
  // operating counters
  logic [11:0] pwr_sec_r;
  logic [11:0] ena_sec_r;
  logic [11:0] fan_sec_r;
  logic [9:0]  wh_r;
  logic [15:0] pwr_hours_r;
  logic [15:0] ena_tenths_r;
  logic [15:0] energy_r;
  logic [15:0] fan_hours_r;
  logic        nv_pwr;
  logic        nv_ena;
  logic        nv_eng;
  logic        nv_fan;
  // restore words come from the external store after power-up
  assign nv_pwr = nv_load && nv_sel == ocfl_pkg::OCFL_NV_POWERED;
  assign nv_ena = nv_load && nv_sel == ocfl_pkg::OCFL_NV_ENABLED;
  assign nv_eng = nv_load && nv_sel == ocfl_pkg::OCFL_NV_ENERGY;
  assign nv_fan = nv_load && nv_sel == ocfl_pkg::OCFL_NV_FAN;

  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      pwr_sec_r   <= 12'h000;
      pwr_hours_r <= 16'h0000;
    end else if (nv_pwr) begin
      pwr_hours_r <= nv_data;
    end else if (sec_tick) begin
      if (pwr_sec_r == `OCFL_SEC_PER_HOUR - 12'h001) begin
        pwr_sec_r   <= 12'h000;
        pwr_hours_r <= pwr_hours_r + 16'h0001;
      end else begin
        pwr_sec_r <= pwr_sec_r + 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      ena_sec_r    <= 12'h000;
      ena_tenths_r <= 16'h0000;
    end else if (cnt_cmd == `OCFL_CMD_ENA_TENTHS) begin
      ena_sec_r    <= 12'h000;
      ena_tenths_r <= 16'h0000;
    end else if (nv_ena) begin
      ena_tenths_r <= nv_data;
    end else if (sec_tick && drive_enabled) begin
      if (ena_sec_r == `OCFL_SEC_PER_TENTH - 12'h001) begin
        ena_sec_r    <= 12'h000;
        // natural 16-bit wrap past 65535 tenths
        ena_tenths_r <= ena_tenths_r + 16'h0001;
      end else begin
        ena_sec_r <= ena_sec_r + 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      wh_r     <= 10'h000;
      energy_r <= 16'h0000;
    end else if (cnt_cmd == `OCFL_CMD_ENERGY) begin
      wh_r     <= 10'h000;
      energy_r <= 16'h0000;
    end else if (nv_eng) begin
      energy_r <= nv_data;
    end else if (energy_wh_pulse) begin
      if (wh_r == `OCFL_WH_PER_KWH - 10'h001) begin
        wh_r     <= 10'h000;
        energy_r <= energy_r + 16'h0001;
      end else begin
        wh_r <= wh_r + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      fan_sec_r   <= 12'h000;
      fan_hours_r <= 16'h0000;
    end else if (cnt_cmd == `OCFL_CMD_FAN_HOURS) begin
      fan_sec_r   <= 12'h000;
      fan_hours_r <= 16'h0000;
    end else if (nv_fan) begin
      fan_hours_r <= nv_data;
    end else if (sec_tick && fan_running) begin
      if (fan_sec_r == `OCFL_SEC_PER_HOUR - 12'h001) begin
        fan_sec_r   <= 12'h000;
        fan_hours_r <= fan_hours_r + 16'h0001;
      end else begin
        fan_sec_r <= fan_sec_r + 12'h001;
      end
    end
  end

  // ==================================================
  // analog output routing and source selects
  logic [15:0] ao1_sel_r;
  logic [15:0] ao2_sel_r;
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      ao1_sel_r <= 16'h0000;
      ao2_sel_r <= 16'h0000;
      ao1_data  <= 16'h0000;
      ao2_data  <= 16'h0000;
    end else begin
      if (wr_en && paddr == `OCFL_AO1_SEL_OFS)
        ao1_sel_r <= wword;
      if (wr_en && paddr == `OCFL_AO2_SEL_OFS)
        ao2_sel_r <= wword;
      // other sources live outside this block and read as zero here
      ao1_data <= (ao1_sel_r == `OCFL_AO_ENC_SRC) ? enc_count_r : 16'h0000;
      ao2_data <= (ao2_sel_r == `OCFL_AO_ENC_SRC) ? enc_count_r : 16'h0000;
    end
  end

  // ==================================================
  // active codes and fault capture
  logic [15:0] alarm_r;
  logic [15:0] fault_r;
  logic [15:0] last_speed_r;
  logic        push;
  logic [15:0] push_code;
  assign push      = fault_event | ovl_fault_rise;
  // an external fault in the same cycle takes precedence
  assign push_code = fault_event ? {6'h00, fault_number} : `OCFL_OVL_FAULT_CODE;
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      alarm_r      <= 16'h0000;
      fault_r      <= 16'h0000;
      last_speed_r <= 16'h0000;
    end else begin
      alarm_r <= {6'h00, alarm_number};
      if (push) begin
        fault_r      <= push_code;
        last_speed_r <= enc_speed_r;
      end else if (fault_clear) begin
        fault_r <= 16'h0000;
      end
    end
  end

  // ==================================================
  // fault history chain
  ocfl_slot_if link [HIST_DEPTH+1] ();
  assign link[0].code      = push_code;
  assign link[0].day_month = {3'h0, rtc_day, 4'h0, rtc_month};
  // suspect bit marks context taken before the clock source is valid
  assign link[0].year      = {~rtc_valid, 8'h00, rtc_year};
  assign link[0].time_hm   = {3'h0, rtc_hour, 2'h0, rtc_minute};

  genvar gi;
  generate
    for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_slot
      ocfl_hist_slot u_slot (
        .core_clk (core_clk),
        .rst_s_b  (rst_s_b),
        .shift    (push),
        .prev     (link[gi]),
        .cur      (link[gi+1])
      );
    end
  endgenerate

  logic [15:0] hist_word [HIST_DEPTH][4];
  generate
    for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_view
      assign hist_word[gi][0] = link[gi+1].code;
      assign hist_word[gi][1] = link[gi+1].day_month;
      assign hist_word[gi][2] = link[gi+1].year;
      assign hist_word[gi][3] = link[gi+1].time_hm;
    end
  endgenerate

  // ==================================================
  // read mux and apb answer
  logic [15:0] rd_word;
  logic        rd_hit;
  logic [7:0]  hofs;
  assign hofs = paddr - `OCFL_HIST_BASE_OFS;
  always_comb begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    case (paddr)
      `OCFL_FAN_SPEED_OFS:   rd_word = fan_rpm_r;
      `OCFL_OVL_LEVEL_OFS:   rd_word = ovl_level_r;
      `OCFL_ENC_SPEED_OFS:   rd_word = enc_speed_r;
      `OCFL_ENC_COUNT_OFS:   rd_word = enc_count_r;
      `OCFL_PWR_HOURS_OFS:   rd_word = pwr_hours_r;
      `OCFL_ENA_TENTHS_OFS:  rd_word = ena_tenths_r;
      `OCFL_ENERGY_OFS:      rd_word = energy_r;
      `OCFL_FAN_HOURS_OFS:   rd_word = fan_hours_r;
      `OCFL_ALARM_OFS:       rd_word = alarm_r;
      `OCFL_FAULT_OFS:       rd_word = fault_r;
      `OCFL_CNT_RST_CMD_OFS: rd_word = 16'h0000;
      `OCFL_AO1_SEL_OFS:     rd_word = ao1_sel_r;
      `OCFL_AO2_SEL_OFS:     rd_word = ao2_sel_r;
      `OCFL_LAST_SPEED_OFS:  rd_word = last_speed_r;
      default: begin
        if (paddr >= `OCFL_HIST_BASE_OFS && paddr <= `OCFL_HIST_LAST_OFS
            && paddr[1:0] == 2'b00)
          rd_word = hist_word[hofs[7:4]][hofs[3:2]];
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  // one wait-free access cycle: answer raised in the cycle after setup
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      prdata  <= (psel && !penable && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

endmodule

// *** shared/ocfl_map.svh ***
// register offsets, command codes and fixed figures of the counters and fault log
`ifndef OCFL_MAP_SVH
`define OCFL_MAP_SVH

// ==================================================
// register byte offsets
`define OCFL_FAN_SPEED_OFS     8'h00
`define OCFL_OVL_LEVEL_OFS     8'h04
`define OCFL_ENC_SPEED_OFS     8'h08
`define OCFL_ENC_COUNT_OFS     8'h0c
`define OCFL_PWR_HOURS_OFS     8'h10
`define OCFL_ENA_TENTHS_OFS    8'h14
`define OCFL_ENERGY_OFS        8'h18
`define OCFL_FAN_HOURS_OFS     8'h1c
`define OCFL_ALARM_OFS         8'h20
`define OCFL_FAULT_OFS         8'h24
`define OCFL_CNT_RST_CMD_OFS   8'h28
`define OCFL_AO1_SEL_OFS       8'h2c
`define OCFL_AO2_SEL_OFS       8'h30
`define OCFL_LAST_SPEED_OFS    8'h34
`define OCFL_HIST_BASE_OFS     8'h40
`define OCFL_HIST_LAST_OFS     8'hdc

// ==================================================
// counter reset command values
`define OCFL_CMD_FAN_HOURS     16'h0002
`define OCFL_CMD_ENA_TENTHS    16'h0003
`define OCFL_CMD_ENERGY        16'h0004

// ==================================================
// limits and codes
`define OCFL_OVL_FULL          16'h0064
`define OCFL_OVL_FAULT_CODE    16'h0048
`define OCFL_ENC_MAX           16'h9c40
`define OCFL_FAN_MAX           16'h3a98
`define OCFL_AO_ENC_SRC        16'h0031
`define OCFL_SEC_PER_HOUR      12'he10
`define OCFL_SEC_PER_TENTH     12'h168
`define OCFL_WH_PER_KWH        10'h3e8
`define OCFL_SPD_SHIFT         3
`define OCFL_SUSPECT_BIT       15
`define OCFL_CLOCK_HZ          25000000

`endif

// *** shared/ocfl_pkg.sv ***
// shared types of the counters and fault log block
package ocfl_pkg;

  // ==================================================
  // which non-volatile counter a restore word goes to
  typedef enum logic [1:0] {
    OCFL_NV_POWERED,
    OCFL_NV_ENABLED,
    OCFL_NV_ENERGY,
    OCFL_NV_FAN
  } ocfl_nv_sel_type;

  typedef logic [15:0] ocfl_word_type;

endpackage

// *** shared/ocfl_slot_if.sv ***
// one fault history record travelling between slots
`timescale 1ns/1ns
interface ocfl_slot_if;
  ocfl_pkg::ocfl_word_type code;
  ocfl_pkg::ocfl_word_type day_month;
  ocfl_pkg::ocfl_word_type year;
  ocfl_pkg::ocfl_word_type time_hm;

  modport drv (output code, output day_month, output year, output time_hm);
  modport rcv (input code, input day_month, input year, input time_hm);
endinterface

// *** src/ocfl_hist_slot.sv ***
// one slot of the fault history shift log
`timescale 1ns/1ns
module ocfl_hist_slot (
  input  wire logic   core_clk,
  input  wire logic   rst_s_b,
  input  wire logic   shift,
  ocfl_slot_if.rcv    prev,
  ocfl_slot_if.drv    cur
);

  // ==================================================
  // all four fields move on the same edge
  always_ff @(posedge core_clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      cur.code      <= 16'h0000;
      cur.day_month <= 16'h0000;
      cur.year      <= 16'h0000;
      cur.time_hm   <= 16'h0000;
    end else if (shift) begin
      cur.code      <= prev.code;
      cur.day_month <= prev.day_month;
      cur.year      <= prev.year;
      cur.time_hm   <= prev.time_hm;
    end
  end

endmodule

// *** tb/ocfl_top_monitor.sv ***
// assertion checker on the ports of the counters and fault log
`timescale 1ns/1ns
`include "ocfl_map.svh"
module ocfl_top_monitor (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fault_clear,
  input wire logic        motor_overload_fault,
  input wire logic [15:0] ao1_data,
  input wire logic [15:0] ao2_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==================================================
  // address decode and transfer steps
  logic bad_addr;
  assign bad_addr = (paddr[1:0] != 2'b00) || (paddr > `OCFL_HIST_LAST_OFS) ||
                    (paddr > `OCFL_LAST_SPEED_OFS && paddr < `OCFL_HIST_BASE_OFS);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    psel && penable && pready;
  endsequence
  // ==================================================
  // properties
  xfer_shape_a: assert property (
    setup_s |=> answer_s ##1 !pready) else $error("answer not one cycle after setup");
  stray_ready_a: assert property (
    !(psel && !penable) |=> !pready) else $error("pready without setup");
  bad_addr_err_a: assert property (
    psel && !penable && bad_addr |=> pslverr) else $error("no error on unmapped address");
  good_addr_ok_a: assert property (
    psel && !penable && !bad_addr |=> !pslverr) else $error("error on mapped address");
  idle_rdata_a: assert property (
    !pready |-> prdata == 32'h0) else $error("read data outside answer");
  upper_half_a: assert property (
    pready |-> prdata[31:16] == 16'h0) else $error("upper read half not zero");
  ao_range_a: assert property (
    ao1_data <= `OCFL_ENC_MAX && ao2_data <= `OCFL_ENC_MAX) else $error("analog data range");
  ovl_hold_a: assert property (
    motor_overload_fault && !fault_clear |=> motor_overload_fault)
    else $error("overload fault dropped without clear");
endmodule

bind ocfl_top ocfl_top_monitor ocfl_top_monitor_inst (.core_clk, .rst_b, .paddr, .psel,
  .penable, .prdata, .pready, .pslverr, .fault_clear, .motor_overload_fault, .ao1_data,
  .ao2_data);

// *** tb/ocfl_keypad_model.sv ***
// keypad side apb master reading and writing the monitor registers
`timescale 1ns/1ns
module ocfl_keypad_model (
  input  wire logic        core_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic [7:0]       paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata
);
  initial begin
    {paddr, psel, penable, pwrite, pwdata} = '0;
  end
  // ==================================================
  // one transfer; request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** tb/tb_ocfl_top.sv ***
// self-checking bench of the counters and fault log
`timescale 1ns/1ns
`include "ocfl_map.svh"
module tb_ocfl_top;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic fan_tach_pulse, fan_running, enc_step, enc_dir_cw, ovl_over_current, e;
  logic drive_enabled, energy_wh_pulse, fault_event, fault_clear, rtc_valid, nv_load;
  logic [9:0]  alarm_number, fault_number, code;
  logic [4:0]  rtc_day, rtc_hour;
  logic [3:0]  rtc_month;
  logic [6:0]  rtc_year;
  logic [5:0]  rtc_minute;
  logic [1:0]  nv_sel;
  logic [15:0] nv_data, ao1_data, ao2_data;
  logic        motor_overload_fault;
  logic [63:0] hq[$];
  int          num_errors, check_count, seed;

  ocfl_top #(.SEC_CYC(10), .FAN_GATE_CYC(20), .ENC_WIN_CYC(16), .OVL_TICK_CYC(4))
  ocfl_top_inst (.core_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .fan_tach_pulse, .fan_running, .enc_step, .enc_dir_cw,
    .ovl_over_current, .drive_enabled, .energy_wh_pulse, .alarm_number, .fault_event,
    .fault_number, .fault_clear, .rtc_day, .rtc_month, .rtc_year, .rtc_hour, .rtc_minute,
    .rtc_valid, .nv_load, .nv_sel, .nv_data, .motor_overload_fault, .ao1_data, .ao2_data);
  ocfl_keypad_model ocfl_keypad_model_inst (.core_clk, .prdata, .pready, .pslverr, .paddr,
    .psel, .penable, .pwrite, .pwdata);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    ocfl_keypad_model_inst.xfer(1'b0, a, 32'h0, d, e);
    chk(d[31:16], 16'h0);
    chk(d[15:0], exp);
    chk({15'h0, e}, 16'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    ocfl_keypad_model_inst.xfer(1'b1, a, {16'h0, v}, d, e);
    chk({15'h0, e}, 16'h0);
  endtask
  task automatic nv(input logic [1:0] s, input logic [15:0] v);
    @(posedge core_clk);
    {nv_load, nv_sel, nv_data} <= {1'b1, s, v};
    @(posedge core_clk);
    nv_load <= 1'b0;
  endtask
  task automatic step(input logic cw);
    @(posedge core_clk);
    {enc_step, enc_dir_cw} <= {1'b1, cw};
    @(posedge core_clk);
    enc_step <= 1'b0;
  endtask
  // model entry: code, day/month, year with suspect flag, hour/minute
  function automatic logic [63:0] ent(input logic [15:0] c);
    return {c, 3'h0, rtc_day, 4'h0, rtc_month, !rtc_valid, 8'h00, rtc_year,
            3'h0, rtc_hour, 2'h0, rtc_minute};
  endfunction
  task automatic set_rtc;
    rtc_day <= 5'($urandom_range(31));
    rtc_month <= 4'($urandom_range(12));
    rtc_year <= 7'($urandom_range(99));
    rtc_hour <= 5'($urandom_range(23));
    rtc_minute <= 6'($urandom_range(59));
    rtc_valid <= 1'($urandom_range(1));
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==================================================
  // watchdog, well beyond the roughly 50k cycles of the run
  initial begin
    repeat (80000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
  // ==================================================
  // scenarios
  initial begin
    {fan_tach_pulse, fan_running, enc_step, enc_dir_cw, ovl_over_current, drive_enabled,
     energy_wh_pulse, fault_event, fault_clear, rtc_valid, nv_load} = '0;
    {alarm_number, fault_number, rtc_day, rtc_hour, rtc_month, rtc_year} = '0;
    {rtc_minute, nv_sel, nv_data, rst_b, num_errors, check_count} = '0;
    seed = $urandom(32'h234edcdb);
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    ocfl_keypad_model_inst.xfer(1'b0, 8'h3c, 32'h0, d, e);
    chk({d[15:0] | d[31:16]}, 16'h0);
    chk({15'h0, e}, 16'h1);
    ocfl_keypad_model_inst.xfer(1'b1, 8'h2e, 32'h31, d, e);
    chk({15'h0, e}, 16'h1);
    for (int i = 0; i < 4; i++) nv(2'(i), 16'hffff);
    for (int i = 0; i < 4; i++) rdchk(8'(16 + 4 * i), 16'hffff);
    // enabled and energy wrap together; fan stays off so its hours hold
    drive_enabled <= 1'b1;
    repeat (1000) begin
      @(posedge core_clk) energy_wh_pulse <= 1'b1;
      @(posedge core_clk) energy_wh_pulse <= 1'b0;
    end
    repeat (2000) @(posedge core_clk);
    drive_enabled <= 1'b0;
    repeat (3700) @(posedge core_clk);
    rdchk(`OCFL_ENA_TENTHS_OFS, 16'h0);
    rdchk(`OCFL_ENERGY_OFS, 16'h0);
    rdchk(`OCFL_FAN_HOURS_OFS, 16'hffff);
    for (int c = 2; c <= 4; c++) begin
      for (int i = 1; i < 4; i++) nv(2'(i), 16'h0005);
      wr(`OCFL_CNT_RST_CMD_OFS, 16'(c));
      for (int i = 1; i < 4; i++)
        rdchk(8'(16 + 4 * i), (c == ((i == 3) ? 2 : i + 2)) ? 16'h0 : 16'h5);
    end
    step(1'b0);
    rdchk(`OCFL_ENC_COUNT_OFS, `OCFL_ENC_MAX);
    step(1'b1);
    step(1'b1);
    rdchk(`OCFL_ENC_COUNT_OFS, 16'h1);
    for (int k = 0; k < 2; k++) begin
      wr(`OCFL_AO1_SEL_OFS, (k == 0) ? `OCFL_AO_ENC_SRC : 16'h0);
      wr(`OCFL_AO2_SEL_OFS, (k == 1) ? `OCFL_AO_ENC_SRC : 16'h0);
      repeat (3) @(posedge core_clk);
      chk(ao1_data, 16'(k == 0));
      chk(ao2_data, 16'(k == 1));
    end
    // tach every cycle: 20 pulses per gate, 2 per rev; a step every cycle: 16 per window
    {fan_tach_pulse, enc_step, enc_dir_cw} <= 3'b111;
    repeat (1000) @(posedge core_clk);
    rdchk(`OCFL_FAN_SPEED_OFS, 16'(20 * 60 / 2));
    rdchk(`OCFL_ENC_SPEED_OFS, 16'h0010);
    {fan_tach_pulse, enc_step} <= 2'b00;
    set_rtc();
    ovl_over_current <= 1'b1;
    repeat (420) @(posedge core_clk);
    chk({15'h0, motor_overload_fault}, 16'h1);
    rdchk(`OCFL_OVL_LEVEL_OFS, `OCFL_OVL_FULL);
    hq.push_front(ent(`OCFL_OVL_FAULT_CODE));
    ovl_over_current <= 1'b0;
    repeat (420) @(posedge core_clk);
    fault_clear <= 1'b1;
    @(posedge core_clk) fault_clear <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({15'h0, motor_overload_fault}, 16'h0);
    repeat (11) begin
      code = 10'($urandom_range(999));
      @(posedge core_clk);
      set_rtc();
      {fault_event, fault_number} <= {1'b1, code};
      @(posedge core_clk) fault_event <= 1'b0;
      hq.push_front(ent({6'h0, code}));
      repeat (3) @(posedge core_clk);
      rdchk(`OCFL_FAULT_OFS, {6'h0, code});
    end
    alarm_number <= 10'($urandom_range(999));
    repeat (2) @(posedge core_clk);
    rdchk(`OCFL_ALARM_OFS, {6'h0, alarm_number});
    // slot k: code, day/month, year, time at 16-byte stride
    for (int k = 0; k < 10; k++) begin
      rdchk(8'(64 + 16 * k), hq[k][63:48]);
      rdchk(8'(68 + 16 * k), hq[k][47:32]);
      rdchk(8'(72 + 16 * k), hq[k][31:16]);
      rdchk(8'(76 + 16 * k), hq[k][15:0]);
    end
    // past one hour of ticks but short of two, so the restored 16'hffff wraps once
    repeat (40000) @(posedge core_clk);
    rdchk(`OCFL_PWR_HOURS_OFS, 16'h0000);
    print_verdict();
  end
endmodule
